// file: isac_regs.v
// I2C register block: error status, clock control, data and own address,
// with the control and transfer status bits, an AHB-Lite slave port,
// an address matcher watching SCL/SDA, and a strobe port to the shift engine.
// Assumes the shift engine runs on clock_i and gives one-cycle event strobes;
// SCL and SDA are open-drain pins combined outside from the enables.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "isac_defs.vh"

module isac_regs
(
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire hready_i,
	input wire [31:0] hwdata_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// I2C pins, open drain
	input wire scl_i,
	input wire sda_i,
	output wire scl_o,
	output wire scl_oe_o,
	output wire sda_o,
	output wire sda_oe_o,
	// Shift engine event strobes
	input wire eng_ack_missing_i,
	input wire eng_arb_lost_i,
	input wire eng_in_ack_bit_i,
	input wire eng_byte_done_i,
	input wire eng_byte_tx_i,
	input wire eng_start_sent_i,
	input wire eng_stop_sent_i,
	input wire eng_rx_valid_i,
	input wire [7:0] eng_rx_byte_i,
	// Shift engine controls
	output wire tx_go_o,
	output wire [7:0] tx_byte_o,
	output wire rx_next_o,
	output wire fast_mode_o,
	output wire [6:0] scl_div_o,
	output wire start_req_o,
	output wire stop_req_o,
	output wire ack_en_o,
	output wire master_mode_o,
	// CPU interrupt
	input wire cpu_irq_mask_i,
	output wire irq_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [7:0] dr_q; // Data byte
	reg [7:0] oar_q; // Own slave address
	reg [7:0] ccr_q; // Speed mode and divider
	reg pe_q, general_call_enable_q, start_q, ack_q, stop_q, ite_q; // Control bits
	reg sb_q, msl_q, adsl_q, btf_q, busy_q, tra_q; // Transfer status
	reg af_q, stop_seen_flag_q, arbitration_lost_q, bus_error_flag_q, general_call_flag_q; // Error status
	reg sr1_seen_q; // Transfer status read, awaiting data access
	reg [2:0] scl_s_q, sda_s_q; // Sync stages plus edge history
	reg [3:0] bitcnt_q; // SCL rises since start or last ack
	reg [7:0] shift_q; // Incoming byte
	reg addr_ph_q; // First byte after start
	reg ack_pend_q; // Address matched, ack to drive
	reg ack_drv_q; // Driving SDA low for ack
	reg acked_q; // We acknowledged in this transfer
	reg rd_pend_q, wr_pend_q; // AHB data phase kinds
	reg [7:0] idx_q; // AHB data phase register index
	reg map_q; // AHB data phase hits a register
	reg [31:0] hrdata_q;
	reg hready_q;
	reg scl_oe_q, sda_oe_q;
	reg tx_go_q, rx_next_q, irq_q;
	wire scl_rise, scl_fall, start_det, stop_det;
	wire [7:0] rx_full;
	wire addr_hit, gc_hit, af_set, arbitration_lost_set, bus_error_flag_set, stop_seen_flag_set;
	wire event_pending;
	wire a_take;
	wire [7:0] a_idx;
	wire a_map;
	wire rd_es, rd_ts, rd_dr, wr_dr, wr_cb, wr_oar, wr_ccr;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Index from a byte address; registers sit one per aligned word
	function [7:0] idx_of;
		input [31:0] a;
		begin
			idx_of = a[9:2];
		end
	endfunction

	// True when an index names one of the six registers
	function mapped;
		input [31:0] a;
		reg [7:0] i;
		begin
			i = a[9:2];
			mapped = (a[31:10] == 22'h000000) && (a[1:0] == 2'h0) &&
				(i == `ISAC_IDX_DR || i == `ISAC_IDX_OAR ||
				i == `ISAC_IDX_CCR || i == `ISAC_IDX_ES ||
				i == `ISAC_IDX_TS || i == `ISAC_IDX_CB);
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------
	// Stage 0 feeds stage 1 only; edges come from stages 1 and 2
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
		end
	end

	assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
	assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
	// SDA moving while SCL stays high marks start or stop
	assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

	// ----------------------------------------
	// Event qualification
	// ----------------------------------------
	assign rx_full = {shift_q[6:0], sda_s_q[1]};
	// Bit 0 is the direction bit and is not compared
	assign addr_hit = (rx_full[7:1] == oar_q[7:1]) &&
		(rx_full != `ISAC_ADDR_NEVER);
	assign gc_hit = general_call_enable_q && (rx_full == `ISAC_ADDR_GCALL);
	assign af_set = pe_q & eng_ack_missing_i;
	// The acknowledge slot of a master receive is not arbitrated
	assign arbitration_lost_set = pe_q & eng_arb_lost_i & ~eng_in_ack_bit_i;
	// A start or stop inside a byte is misplaced
	// The first clock of a byte is where a stop or repeated start belongs
	assign bus_error_flag_set = pe_q & busy_q & (start_det | stop_det) &
		(bitcnt_q > `ISAC_BITS_FIRST) & (bitcnt_q != `ISAC_BITS_ACK);
	assign stop_seen_flag_set = pe_q & stop_det & acked_q & ~msl_q;
	assign event_pending = sb_q | adsl_q | btf_q | af_q | stop_seen_flag_q | arbitration_lost_q | bus_error_flag_q;

	// ----------------------------------------
	// AHB-Lite decode
	// ----------------------------------------
	assign a_take = hsel_i & hready_i & (htrans_i == `ISAC_HTRANS_NSQ);
	assign a_idx = idx_of(haddr_i);
	assign a_map = mapped(haddr_i);
	// Read side effects happen in the wait cycle of the data phase
	assign rd_es = rd_pend_q & map_q & (idx_q == `ISAC_IDX_ES);
	assign rd_ts = rd_pend_q & map_q & (idx_q == `ISAC_IDX_TS);
	assign rd_dr = rd_pend_q & map_q & (idx_q == `ISAC_IDX_DR);
	assign wr_dr = wr_pend_q & map_q & (idx_q == `ISAC_IDX_DR);
	assign wr_cb = wr_pend_q & map_q & (idx_q == `ISAC_IDX_CB);
	assign wr_oar = wr_pend_q & map_q & (idx_q == `ISAC_IDX_OAR);
	assign wr_ccr = wr_pend_q & map_q & (idx_q == `ISAC_IDX_CCR);

	// Address phase capture, one wait state on reads only
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_pend_q <= 1'b0;
			wr_pend_q <= 1'b0;
			idx_q <= `ISAC_ZERO8;
			map_q <= 1'b0;
			hready_q <= 1'b1;
		end
		else
		begin
			rd_pend_q <= a_take & ~hwrite_i;
			wr_pend_q <= a_take & hwrite_i;
			if (a_take)
			begin
				idx_q <= a_idx;
				map_q <= a_map;
			end
			// Low for exactly the first data cycle of a read
			hready_q <= ~(a_take & ~hwrite_i);
		end
	end

	// Read data; reserved and unmapped bits read zero
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			hrdata_q <= 32'h00000000;
		else if (rd_pend_q)
		begin
			hrdata_q <= 32'h00000000;
			if (map_q)
			begin
				case (idx_q)
				`ISAC_IDX_DR: hrdata_q[7:0] <= dr_q;
				`ISAC_IDX_OAR: hrdata_q[7:0] <= oar_q;
				`ISAC_IDX_CCR: hrdata_q[7:0] <= ccr_q;
				`ISAC_IDX_ES: hrdata_q[7:0] <= {3'h0, af_q, stop_seen_flag_q, arbitration_lost_q,
					bus_error_flag_q, general_call_flag_q};
				`ISAC_IDX_TS: hrdata_q[7:0] <= {event_pending, 1'b0, tra_q, busy_q,
					btf_q, adsl_q, msl_q, sb_q};
				`ISAC_IDX_CB: hrdata_q[7:0] <= {2'h0, pe_q, general_call_enable_q, start_q,
					ack_q, stop_q, ite_q};
				default: hrdata_q[7:0] <= `ISAC_ZERO8;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// Address and clock settings are kept while switched off
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			oar_q <= `ISAC_ZERO8;
			ccr_q <= `ISAC_ZERO8;
			dr_q <= `ISAC_ZERO8;
		end
		else
		begin
			if (wr_oar)
				oar_q <= hwdata_i[7:0];
			if (wr_ccr)
				ccr_q <= hwdata_i[7:0];
			// Software write wins over an engine byte in the same cycle
			if (wr_dr)
				dr_q <= hwdata_i[7:0];
			else if (eng_rx_valid_i & pe_q)
				dr_q <= eng_rx_byte_i;
		end
	end

	// Control bits; while off only the enable and the stop request are writable
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pe_q <= 1'b0;
			general_call_enable_q <= 1'b0;
			start_q <= 1'b0;
			ack_q <= 1'b0;
			stop_q <= 1'b0;
			ite_q <= 1'b0;
		end
		else
		begin
			if (wr_cb)
			begin
				pe_q <= hwdata_i[`ISAC_CB_PE];
				stop_q <= hwdata_i[`ISAC_CB_STOP];
				// First write with the block off takes only the enable and the stop request
				if (pe_q)
				begin
					general_call_enable_q <= hwdata_i[`ISAC_CB_GENERAL_CALL_ENABLE];
					start_q <= hwdata_i[`ISAC_CB_START];
					ack_q <= hwdata_i[`ISAC_CB_ACK];
					ite_q <= hwdata_i[`ISAC_CB_ITE];
				end
			end
			else
			begin
				if (eng_start_sent_i)
					start_q <= 1'b0;
				if (eng_stop_sent_i & msl_q)
					stop_q <= 1'b0;
			end
			// Stop request is the one bit kept while off
			if (!pe_q && !(wr_cb && hwdata_i[`ISAC_CB_PE]))
			begin
				general_call_enable_q <= 1'b0;
				start_q <= 1'b0;
				ack_q <= 1'b0;
				ite_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Status flags; clear first, then set, so a set wins, except busy and master mode, where the clear comes last and wins
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sb_q <= 1'b0;
			msl_q <= 1'b0;
			adsl_q <= 1'b0;
			btf_q <= 1'b0;
			tra_q <= 1'b0;
			busy_q <= 1'b0;
			af_q <= 1'b0;
			stop_seen_flag_q <= 1'b0;
			arbitration_lost_q <= 1'b0;
			bus_error_flag_q <= 1'b0;
			general_call_flag_q <= 1'b0;
			sr1_seen_q <= 1'b0;
		end
		else if (!pe_q)
		begin
			// Everything but the bus busy flag is held clear
			sb_q <= 1'b0;
			msl_q <= 1'b0;
			adsl_q <= 1'b0;
			btf_q <= 1'b0;
			tra_q <= 1'b0;
			af_q <= 1'b0;
			stop_seen_flag_q <= 1'b0;
			arbitration_lost_q <= 1'b0;
			bus_error_flag_q <= 1'b0;
			general_call_flag_q <= 1'b0;
			sr1_seen_q <= 1'b0;
		end
		else
		begin
			// Reading error status clears the error flags but not the general call flag
			if (rd_es)
			begin
				af_q <= 1'b0;
				stop_seen_flag_q <= 1'b0;
				arbitration_lost_q <= 1'b0;
				bus_error_flag_q <= 1'b0;
			end
			if (rd_ts)
			begin
				sr1_seen_q <= 1'b1;
				adsl_q <= 1'b0;
			end
			// A data access after a status read ends start and byte flags
			if ((rd_dr | wr_dr) & sr1_seen_q)
			begin
				sr1_seen_q <= 1'b0;
				btf_q <= 1'b0;
				sb_q <= 1'b0;
				tra_q <= 1'b0;
			end
			// Bus activity
			if (start_det)
				busy_q <= 1'b1;
			if (stop_det | bus_error_flag_set)
				busy_q <= 1'b0;
			// Master mode follows a start request
			if (wr_cb & hwdata_i[`ISAC_CB_START])
				msl_q <= 1'b1;
			if (stop_det | arbitration_lost_set)
				msl_q <= 1'b0;
			if (stop_det)
				general_call_flag_q <= 1'b0;
			if (arbitration_lost_set | stop_seen_flag_set)
				tra_q <= 1'b0;
			// Event sets
			if (eng_start_sent_i)
				sb_q <= 1'b1;
			if (eng_byte_done_i)
			begin
				btf_q <= 1'b1;
				tra_q <= eng_byte_tx_i;
			end
			if (af_set)
				af_q <= 1'b1;
			if (arbitration_lost_set)
				arbitration_lost_q <= 1'b1;
			if (bus_error_flag_set)
				bus_error_flag_q <= 1'b1;
			if (stop_seen_flag_set)
				stop_seen_flag_q <= 1'b1;
			if (scl_rise && addr_ph_q && bitcnt_q == 4'h7 && ack_q && !msl_q && gc_hit)
				general_call_flag_q <= 1'b1;
			// Address flag waits for the end of our acknowledge clock, so the
			// SCL hold that it causes starts while SCL is already low
			if (scl_fall && bitcnt_q == `ISAC_BITS_ACK && ack_drv_q)
				adsl_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Slave address receiver and acknowledge
	// ----------------------------------------
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bitcnt_q <= 4'h0;
			shift_q <= `ISAC_ZERO8;
			addr_ph_q <= 1'b0;
			ack_pend_q <= 1'b0;
			ack_drv_q <= 1'b0;
			acked_q <= 1'b0;
		end
		else if (!pe_q || stop_det)
		begin
			bitcnt_q <= 4'h0;
			addr_ph_q <= 1'b0;
			ack_pend_q <= 1'b0;
			ack_drv_q <= 1'b0;
			acked_q <= 1'b0;
		end
		else if (start_det)
		begin
			// Also covers a repeated start
			bitcnt_q <= 4'h0;
			addr_ph_q <= 1'b1;
			ack_pend_q <= 1'b0;
			ack_drv_q <= 1'b0;
		end
		else
		begin
			if (scl_rise && bitcnt_q != `ISAC_BITS_ACK)
			begin
				shift_q <= rx_full;
				bitcnt_q <= bitcnt_q + 4'h1;
				if (addr_ph_q && bitcnt_q == 4'h7 && ack_q && !msl_q &&
					(addr_hit | gc_hit))
					ack_pend_q <= 1'b1;
			end
			if (scl_fall && bitcnt_q == `ISAC_BITS_ADDR && ack_pend_q)
			begin
				ack_drv_q <= 1'b1;
				acked_q <= 1'b1;
			end
			if (scl_fall && bitcnt_q == `ISAC_BITS_ACK)
			begin
				bitcnt_q <= 4'h0;
				addr_ph_q <= 1'b0;
				ack_pend_q <= 1'b0;
				ack_drv_q <= 1'b0;
			end
			// Data bytes acknowledged by the engine also arm stop detection
			if (eng_byte_done_i && ack_q && !eng_byte_tx_i)
				acked_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Pin drivers, engine strobes and interrupt
	// ----------------------------------------
	// Clock hold comes only from start, byte-done and address flags
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			tx_go_q <= 1'b0;
			rx_next_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			// A slave stop request lets SCL go
			scl_oe_q <= pe_q & (sb_q | btf_q | adsl_q) & ~(stop_q & ~msl_q);
			sda_oe_q <= pe_q & ack_drv_q;
			tx_go_q <= pe_q & wr_dr;
			// Next byte is fetched only once the last was read
			rx_next_q <= pe_q & rd_dr & btf_q & ~tra_q;
			irq_q <= pe_q & ite_q & ~cpu_irq_mask_i & event_pending;
		end
	end

	// ----------------------------------------
	// Outputs, from flip-flops except the constant response and pin levels
	// ----------------------------------------
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = 1'b0;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign tx_go_o = tx_go_q;
	assign tx_byte_o = dr_q;
	assign rx_next_o = rx_next_q;
	assign fast_mode_o = ccr_q[7];
	assign scl_div_o = ccr_q[6:0];
	assign start_req_o = start_q;
	assign stop_req_o = stop_q;
	assign ack_en_o = ack_q;
	assign master_mode_o = msl_q;
	assign irq_o = irq_q;

endmodule

// file: isac_defs.vh
// Constants for the I2C status, address and clock register block.
// Assumes inclusion by isac_regs.v only; definitions only, no logic.
`ifndef ISAC_DEFS_VH
`define ISAC_DEFS_VH

// ----------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------
`define ISAC_IDX_DR 8'h39
`define ISAC_IDX_OAR 8'h3b
`define ISAC_IDX_CCR 8'h3c
`define ISAC_IDX_ES 8'h3d
`define ISAC_IDX_TS 8'h3e
`define ISAC_IDX_CB 8'h3f

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define ISAC_CB_PE 5
`define ISAC_CB_GENERAL_CALL_ENABLE 4
`define ISAC_CB_START 3
`define ISAC_CB_ACK 2
`define ISAC_CB_STOP 1
`define ISAC_CB_ITE 0
`define ISAC_ZERO8 8'h00
`define ISAC_ADDR_NEVER 8'h01
`define ISAC_ADDR_GCALL 8'h00
`define ISAC_BITS_ADDR 4'h8
`define ISAC_BITS_ACK 4'h9
// First clock of a byte, where a stop or repeated start is in place
`define ISAC_BITS_FIRST 4'h1
`define ISAC_HTRANS_NSQ 2'h2

`endif

// file: isac_regs_asserts.sv
// Checker for the I2C register block, watching only its top-level ports.
// Assumes one clock domain and the AHB-Lite byte addresses of the register map.
`timescale 1ns/1ps

module isac_regs_asserts
(
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Bus side
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire hready_i,
	input wire [31:0] hwdata_i,
	input wire [31:0] hrdata_o,
	input wire hreadyout_o,
	input wire hresp_o,
	// Pins and engine side
	input wire scl_o,
	input wire sda_o,
	input wire sda_oe_o,
	input wire eng_arb_lost_i,
	input wire eng_in_ack_bit_i,
	input wire tx_go_o,
	input wire rx_next_o,
	input wire [7:0] tx_byte_o,
	input wire fast_mode_o,
	input wire [6:0] scl_div_o,
	input wire master_mode_o,
	input wire cpu_irq_mask_i,
	input wire irq_o
);
	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	wire take = hsel_i & hready_i & (htrans_i == 2'h2); // Transfer accepted this edge
	wire rd_es = take & ~hwrite_i & (haddr_i[9:0] == 10'h0f4); // Error status read
	wire wr_dr = take & hwrite_i & (haddr_i[9:0] == 10'h0e4); // Data register write
	wire wr_cc = take & hwrite_i & (haddr_i[9:0] == 10'h0f0); // Clock control write
	wire rd_dr = take & ~hwrite_i & (haddr_i[9:0] == 10'h0e4); // Data register read

	default clocking cb_main @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_RD_WAIT:
		assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read data phase lacks its single wait state");
	AST_ES_RSVD:
		assert property (rd_es |-> ##2 (hrdata_o[31:5] == 27'h0))
		else $error("error status upper bits not zero");
	AST_TX_GO:
		assert property ($rose(tx_go_o) |-> $past(wr_dr, 2))
		else $error("send pulse without a data write");
	AST_TX_BYTE:
		assert property (tx_go_o |-> tx_byte_o == $past(hwdata_i[7:0]))
		else $error("sent byte differs from written byte");
	AST_CCR:
		assert property (wr_cc |-> ##2 (fast_mode_o == $past(hwdata_i[7])
			&& scl_div_o == $past(hwdata_i[6:0])))
		else $error("speed mode or divider not taken from write");
	AST_ARB_SLAVE:
		assert property (eng_arb_lost_i && !eng_in_ack_bit_i |=> !master_mode_o)
		else $error("still master after lost arbitration");
	AST_IRQ_MASK:
		assert property (cpu_irq_mask_i [*2] |-> !irq_o)
		else $error("interrupt raised while masked");
	AST_PINS_OD:
		assert property (scl_o == 1'b0 && sda_o == 1'b0 && hresp_o == 1'b0)
		else $error("open drain value or response not constant");
	AST_RX_NEXT:
		assert property (rx_next_o |-> $past(rd_dr, 2))
		else $error("next byte fetched without a data read");
	AST_SDA_SLAVE:
		assert property (sda_oe_o |-> !master_mode_o)
		else $error("address acknowledge driven in master mode");
endmodule

// file: isac_i2c_peer.sv
// Behavioural I2C master standing on the far side of the bus pins.
// Assumes open-drain lines with pull-ups, combined by the bench.
`timescale 1ns/1ps

module isac_i2c_peer
(
	// Wire levels
	input wire scl_i,
	input wire sda_i,
	// High means released
	output logic scl_rel_o,
	output logic sda_rel_o
);
	// Idle bus: both lines released, clock stands still between frames
	initial
	begin
		scl_rel_o = 1'b1;
		sda_rel_o = 1'b1;
	end

	// Release SCL and wait, bounded, while the device stretches it
	task scl_up;
		int n;
		begin
			scl_rel_o = 1'b1;
			n = 0;
			while (scl_i !== 1'b1 && n < 200)
			begin
				n++;
				#50;
			end
		end
	endtask

	// One bit, 400 ns period; SDA moves only while SCL is low
	task put_bit(input logic b, output logic r);
		begin
			#50 sda_rel_o = b;
			#150;
			scl_up;
			#100 r = sda_i;
			#100 scl_rel_o = 1'b0;
		end
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task send(input logic [7:0] v, output logic ack);
		logic r;
		begin
			for (int i = 7; i >= 0; i--)
				put_bit(v[i], r);
			put_bit(1'b1, r);
			ack = ~r;
		end
	endtask

	// Start or repeated start: SDA falls while SCL is high
	task start;
		begin
			// Ten extra nanoseconds keep the pins off the block's clock edges
			#60 sda_rel_o = 1'b1;
			scl_up;
			#200 sda_rel_o = 1'b0;
			#200 scl_rel_o = 1'b0;
		end
	endtask

	// Stop: SDA rises while SCL is high, frees the bus
	task stop;
		begin
			#60 sda_rel_o = 1'b0;
			#150;
			scl_up;
			#200 sda_rel_o = 1'b1;
			#200;
		end
	endtask
endmodule

// file: isac_regs_tb.sv
// Self-checking bench for the I2C register block over AHB-Lite.
// Assumes the peer model on the pins and the bench acting as shift engine.
`timescale 1ns/1ps

module isac_regs_tb;
	// ----------------------------------------
	// Stimulus and wires
	// ----------------------------------------
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel_i = 1'b1;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic [7:0] eng_q = 8'h0; // Engine strobes, one bit each
	logic [7:0] rxb_q = 8'h0; // Byte offered by the engine
	logic mask_q = 1'b0; // CPU interrupt mask
	logic [31:0] rd_s; // Read data taken at the answer edge
	logic ack;
	int err_total = 0;
	int cmp_count = 0;
	wire [31:0] hrdata_o;
	wire hreadyout_o, hresp_o, scl_o, scl_oe_o, sda_o, sda_oe_o, scl_rel, sda_rel;
	wire tx_go_o, rx_next_o, fast_mode_o, master_mode_o, irq_o;
	wire [7:0] tx_byte_o;
	wire [6:0] scl_div_o;
	// Wired-AND of the open-drain lines, pull-ups when released
	wire scl_w = scl_rel & (scl_oe_o ? scl_o : 1'b1);
	wire sda_w = sda_rel & (sda_oe_o ? sda_o : 1'b1);

	always #25 clock_i = ~clock_i;

	isac_regs i_isac_regs (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_i(scl_w), .sda_i(sda_w),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.eng_ack_missing_i(eng_q[0]), .eng_arb_lost_i(eng_q[1]),
		.eng_in_ack_bit_i(eng_q[2]), .eng_byte_done_i(eng_q[3]), .eng_byte_tx_i(eng_q[4]),
		.eng_start_sent_i(eng_q[5]), .eng_stop_sent_i(eng_q[6]),
		.eng_rx_valid_i(eng_q[7]), .eng_rx_byte_i(rxb_q), .tx_go_o(tx_go_o),
		.tx_byte_o(tx_byte_o), .rx_next_o(rx_next_o), .fast_mode_o(fast_mode_o),
		.scl_div_o(scl_div_o), .start_req_o(), .stop_req_o(), .ack_en_o(),
		.master_mode_o(master_mode_o), .cpu_irq_mask_i(mask_q), .irq_o(irq_o));

	isac_i2c_peer i_isac_i2c_peer (.scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel),
		.sda_rel_o(sda_rel));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task report_and_stop;
		begin
			$display("mismatches %0d, compares %0d", err_total, cmp_count);
			if (err_total == 0 && cmp_count > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		begin
			cmp_count++;
			if (got !== exp)
			begin
				err_total++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// Wait, bounded, for hready; registered, so the negedge value is the edge value
	task wait_rdy;
		int n;
		begin
			n = 0;
			@(negedge clock_i);
			while (hreadyout_o !== 1'b1 && n < 40)
			begin
				n++;
				@(negedge clock_i);
			end
			rd_s = hrdata_o;
			@(posedge clock_i);
		end
	endtask

	// One single AHB transfer: address phase, then data phase
	task ahb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		begin
			@(posedge clock_i);
			htrans_i <= 2'h2;
			haddr_i <= {22'h0, idx, 2'h0};
			hwrite_i <= w;
			wait_rdy;
			htrans_i <= 2'h0;
			hwdata_i <= {24'h0, wd};
			wait_rdy;
		end
	endtask

	task rdc(input logic [7:0] idx, input logic [7:0] exp);
		begin
			ahb(1'b0, idx, 8'h0);
			chk(rd_s[7:0], exp);
		end
	endtask

	// One-cycle engine strobe
	task eng(input logic [7:0] v);
		begin
			@(posedge clock_i);
			eng_q <= v;
			@(posedge clock_i);
			eng_q <= 8'h0;
		end
	endtask

	task settle;
		begin
			repeat (2) @(posedge clock_i);
			@(negedge clock_i);
		end
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rdc(8'h39, 8'h00);
		rdc(8'h3b, 8'h00);
		rdc(8'h3c, 8'h00);
		rdc(8'h3d, 8'h00);
		rdc(8'h3a, 8'h00);
		ahb(1'b1, 8'h3c, 8'h8a);
		rdc(8'h3c, 8'h8a);
		ahb(1'b1, 8'h3b, 8'ha4);
		ahb(1'b1, 8'h3d, 8'hff);
		rdc(8'h3d, 8'h00);
		// Enable takes two writes: the first sets only the enable
		ahb(1'b1, 8'h3f, 8'h35);
		rdc(8'h3f, 8'h20);
		ahb(1'b1, 8'h3f, 8'h35);
		rdc(8'h3f, 8'h35);
		eng(8'h01);
		settle;
		chk({7'h0, irq_o}, 8'h01);
		@(posedge clock_i);
		mask_q <= 1'b1;
		settle;
		chk({7'h0, irq_o}, 8'h00);
		@(posedge clock_i);
		mask_q <= 1'b0;
		rdc(8'h3d, 8'h10);
		rdc(8'h3d, 8'h00);
		settle;
		chk({7'h0, irq_o}, 8'h00);
		// Arbitration: ignored in the acknowledge bit, else back to slave
		eng(8'h06);
		rdc(8'h3d, 8'h00);
		ahb(1'b1, 8'h3f, 8'h3d);
		settle;
		chk({7'h0, master_mode_o}, 8'h01);
		eng(8'h02);
		settle;
		chk({7'h0, master_mode_o}, 8'h00);
		ahb(1'b1, 8'h3f, 8'h35);
		rdc(8'h3d, 8'h04);
		ahb(1'b1, 8'h39, 8'h5a);
		settle;
		chk(tx_byte_o, 8'h5a);
		@(posedge clock_i);
		rxb_q <= 8'hc3;
		eng(8'h80);
		// Received byte with a missing acknowledge holds SCL until released
		eng(8'h09);
		settle;
		chk({7'h0, scl_oe_o}, 8'h01);
		ahb(1'b1, 8'h3f, 8'h37);
		settle;
		chk({7'h0, scl_oe_o}, 8'h00);
		ahb(1'b1, 8'h3f, 8'h35);
		rdc(8'h3d, 8'h10);
		rdc(8'h3e, 8'h88);
		rdc(8'h39, 8'hc3);
		// Own address with direction bit set, then stop after our acknowledge
		i_isac_i2c_peer.start;
		i_isac_i2c_peer.send(8'ha5, ack);
		chk({7'h0, ack}, 8'h01);
		settle;
		rdc(8'h3e, 8'h94);
		i_isac_i2c_peer.stop;
		rdc(8'h3d, 8'h08);
		// General call, cleared by the stop
		i_isac_i2c_peer.start;
		i_isac_i2c_peer.send(8'h00, ack);
		chk({7'h0, ack}, 8'h01);
		rdc(8'h3d, 8'h01);
		rdc(8'h3e, 8'h94);
		i_isac_i2c_peer.stop;
		rdc(8'h3d, 8'h08);
		i_isac_i2c_peer.start;
		i_isac_i2c_peer.send(8'h01, ack);
		chk({7'h0, ack}, 8'h00);
		i_isac_i2c_peer.stop;
		rdc(8'h3d, 8'h00);
		// Start in mid-byte, then the recovery stop
		i_isac_i2c_peer.start;
		repeat (3) i_isac_i2c_peer.put_bit(1'b0, ack);
		i_isac_i2c_peer.start;
		i_isac_i2c_peer.stop;
		rdc(8'h3d, 8'h02);
		// Switching off clears flags, keeps speed and address
		eng(8'h01);
		ahb(1'b1, 8'h3f, 8'h00);
		rdc(8'h3d, 8'h00);
		rdc(8'h3c, 8'h8a);
		rdc(8'h3b, 8'ha4);
		chk({7'h0, scl_oe_o}, 8'h00);
		report_and_stop;
	end

	// Watchdog well beyond the expected run of some 30 us
	initial
	begin
		#2000000;
		err_total++;
		report_and_stop;
	end
endmodule

bind isac_regs isac_regs_asserts i_isac_regs_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .scl_o(scl_o), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .eng_arb_lost_i(eng_arb_lost_i),
	.eng_in_ack_bit_i(eng_in_ack_bit_i), .tx_go_o(tx_go_o), .rx_next_o(rx_next_o),
	.tx_byte_o(tx_byte_o),
	.fast_mode_o(fast_mode_o), .scl_div_o(scl_div_o), .master_mode_o(master_mode_o),
	.cpu_irq_mask_i(cpu_irq_mask_i), .irq_o(irq_o));
